// ===== ppt_defs.vh
// Constants for the pattern tester: register offsets, field positions, codes, counts.
// Assumes inclusion by bare name from the tester design files only.
`ifndef PPT_DEFS_VH
`define PPT_DEFS_VH

`define PPT_ADDR_STATUS 8'h26
`define PPT_ADDR_IRQ_EN 8'h27
`define PPT_ADDR_CTRL1 8'hE0
`define PPT_ADDR_CTRL2 8'hE1
`define PPT_RESET_VALUE 8'h00

`define PPT_C1_RESYNC 0
`define PPT_C1_CLR_COUNTS 1
`define PPT_C1_SEL_LO 2
`define PPT_C1_SEL_HI 4
`define PPT_C1_RX_INV 5
`define PPT_C1_TX_INV 6
`define PPT_C1_TX_LOAD 7
`define PPT_C2_LEN_LO 0
`define PPT_C2_LEN_HI 3
`define PPT_C2_SINGLE_ERR 4
`define PPT_C2_RATE_LO 5
`define PPT_C2_RATE_HI 7

`define PPT_ST_SYNC 0
`define PPT_ST_LOST 1
`define PPT_ST_ZEROS 2
`define PPT_ST_ONES 3
`define PPT_ST_ERR_OVF 4
`define PPT_ST_BIT_OVF 5
`define PPT_ST_BIT_ERR 6

`define PPT_PAT_PRBS7 3'h0
`define PPT_PAT_PRBS11 3'h1
`define PPT_PAT_PRBS15 3'h2
`define PPT_PAT_QRSS 3'h3
`define PPT_PAT_REPEAT 3'h4
`define PPT_PAT_ALT 3'h5
`define PPT_PAT_STRESS 3'h6
`define PPT_PAT_PRBS9 3'h7

`define PPT_REPEAT_BASE 10'h010
`define PPT_ALT_LAST 10'h00F
`define PPT_STRESS_LAST 10'h1B7
`define PPT_STRESS_BITS 440
`define PPT_QRSS_MAX_ZEROS 4'hE
`define PPT_RUN_LEN 6'h20
`define PPT_SYNC_LAST 6'h1F
`define PPT_LOS_WIN_LAST 6'h3F
`define PPT_LOS_ERRS 4'h6

`define PPT_RATE_E1 24'h00000A
`define PPT_RATE_E2 24'h000064
`define PPT_RATE_E3 24'h0003E8
`define PPT_RATE_E4 24'h002710
`define PPT_RATE_E5 24'h0186A0
`define PPT_RATE_E6 24'h0F4240
`define PPT_RATE_E7 24'h989680

`endif

// ===== ppt_pattern_engine.v
// Pattern engine: pseudorandom, repetitive, alternating-word and stress sequences.
// Assumes adv_i pulses once per bit; seed and slip only matter while the caller hunts.
`timescale 1ns/1ps
`include "ppt_defs.vh"
module ppt_pattern_engine #(
	parameter [`PPT_STRESS_BITS-1:0] STRESS_PAT = {55{8'h55}}
) (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire [2:0] pattern_sel_i,
	input wire [3:0] repeat_length_i,
	input wire [31:0] repeat_pattern_i,
	input wire [7:0] alt_word_count_i,
	input wire load_i,
	input wire adv_i,
	input wire seed_i,
	input wire seed_bit_i,
	input wire slip_i,
	output wire bit_o
);
	reg [19:0] lfsr_reg;
	reg [9:0] idx_reg;
	reg [7:0] word_cnt_reg;
	reg alt_sel_reg;
	reg [3:0] zrun_reg;
	reg [4:0] tap_a;
	reg [4:0] tap_b;
	reg [9:0] last_idx;
	reg fixed_bit;
	wire is_prbs = (pattern_sel_i < `PPT_PAT_REPEAT) || (pattern_sel_i == `PPT_PAT_PRBS9);
	wire fb = lfsr_reg[tap_a] ^ lfsr_reg[tap_b];
	wire forced_one = (pattern_sel_i == `PPT_PAT_QRSS) && (zrun_reg == `PPT_QRSS_MAX_ZEROS);
	// Forced one keeps zero runs bounded in QRSS
	wire prbs_bit = forced_one ? 1'b1 : fb;
	wire [9:0] step = slip_i ? 10'h002 : 10'h001;
	wire [9:0] idx_sum = idx_reg + step;
	wire wrap = idx_sum > last_idx;
	wire [7:0] alt_limit = (alt_word_count_i == 8'h00) ? 8'h01 : alt_word_count_i;
	// A forced one is not part of the register sequence, so it never seeds it
	wire shift_in = (seed_i && ~forced_one) ? seed_bit_i : fb;
	wire out_bit = seed_i ? seed_bit_i : bit_o;

	assign bit_o = is_prbs ? prbs_bit : fixed_bit;

	always @*
	begin
		case (pattern_sel_i)
			`PPT_PAT_PRBS7: tap_a = 5'h06;
			`PPT_PAT_PRBS11: tap_a = 5'h0A;
			`PPT_PAT_PRBS15: tap_a = 5'h0E;
			`PPT_PAT_QRSS: tap_a = 5'h13;
			default: tap_a = 5'h08;
		endcase
		case (pattern_sel_i)
			`PPT_PAT_PRBS7: tap_b = 5'h05;
			`PPT_PAT_PRBS11: tap_b = 5'h08;
			`PPT_PAT_PRBS15: tap_b = 5'h0D;
			`PPT_PAT_QRSS: tap_b = 5'h10;
			default: tap_b = 5'h04;
		endcase
		case (pattern_sel_i)
			`PPT_PAT_REPEAT: last_idx = `PPT_REPEAT_BASE + {6'h00, repeat_length_i};
			`PPT_PAT_ALT: last_idx = `PPT_ALT_LAST;
			default: last_idx = `PPT_STRESS_LAST;
		endcase
		case (pattern_sel_i)
			`PPT_PAT_REPEAT: fixed_bit = repeat_pattern_i[idx_reg[4:0]];
			`PPT_PAT_ALT: fixed_bit = repeat_pattern_i[{alt_sel_reg, idx_reg[3:0]}];
			default: fixed_bit = STRESS_PAT[idx_reg[8:0]];
		endcase
	end

	always @(posedge ref_clk_i)
	begin
		if (sys_rst_i || load_i)
		begin
			lfsr_reg <= 20'hFFFFF;
			idx_reg <= 10'h000;
			word_cnt_reg <= 8'h00;
			alt_sel_reg <= 1'b0;
			zrun_reg <= 4'h0;
		end
		else if (adv_i)
		begin
			if (is_prbs)
			begin
				lfsr_reg <= {lfsr_reg[18:0], shift_in};
				zrun_reg <= out_bit ? 4'h0 : ((zrun_reg == `PPT_QRSS_MAX_ZEROS) ? zrun_reg : zrun_reg + 4'h1);
			end
			else if (wrap)
			begin
				idx_reg <= idx_sum - last_idx - 10'h001;
				if (word_cnt_reg + 8'h01 >= alt_limit)
				begin
					word_cnt_reg <= 8'h00;
					alt_sel_reg <= ~alt_sel_reg;
				end
				else
					word_cnt_reg <= word_cnt_reg + 8'h01;
			end
			else
				idx_reg <= idx_sum;
		end
	end
endmodule // ppt_pattern_engine

// ===== ppt_prbs_pattern_tester.v
// Bit-error-rate tester: generator, checker, status and control registers.
// Assumes a synchronous byte register port and per-bit strobes from the framer.
// Behaviour
// - codes 0,1,2,7 select PRBS 7/11/15/9
// - code 3 gives QRSS, max 14 zeros
// - codes 4,5,6 repetitive, alternating, 55-octet
// - rx invert bit inverts checked data
// - tx invert bit inverts generated data
// - load bit rising edge reloads generator
// - repeat length is 17 plus field
// - checker ignores length for pseudorandom patterns
// - single-error bit rising edge corrupts one bit
// - rate field inserts errors, one per decade
// - sync after 32 matching bits, both edges
// - sync-lost latches on hunt, read clears only while in sync
// - all-zeros after 32 zeros, clear needs one
// - all-ones after 32 ones, clear needs zero
// - 24-bit error counter overflow flag
// - 32-bit bit counter overflow flag
// - bit error flag only while synchronized
// - interrupt enables at 27h, reset masked
// - condition flags interrupt on both edges
`timescale 1ns/1ps
`include "ppt_defs.vh"
module ppt_prbs_pattern_tester #(
	parameter [`PPT_STRESS_BITS-1:0] STRESS_PAT = {55{8'h55}}
) (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire [7:0] bus_addr_i,
	input wire bus_wr_i,
	input wire bus_rd_i,
	input wire [7:0] bus_wdata_i,
	output reg [7:0] bus_rdata_o,
	input wire [31:0] repeat_pattern_i,
	input wire [7:0] alt_word_count_i,
	input wire tx_ready_i,
	output reg tx_valid_o,
	output reg tx_bit_o,
	input wire rx_valid_i,
	input wire rx_bit_i,
	output reg in_sync_o,
	output reg irq_o
);
	reg [7:0] ctrl1_reg;
	reg [7:0] ctrl2_reg;
	reg [7:0] irq_en_reg;
	reg [6:0] status_reg;
	reg [6:0] status_next;
	reg [6:0] pend_reg;
	reg [6:0] pend_next;
	reg [7:0] ctrl1_prev_reg;
	reg ctrl2_sbe_prev_reg;
	reg single_err_reg;
	reg [23:0] rate_cnt_reg;
	reg [23:0] rate_period;
	reg fifo_b_reg;
	reg [1:0] fifo_cnt_reg;
	reg sync_reg;
	reg [5:0] match_cnt_reg;
	reg [5:0] win_cnt_reg;
	reg [3:0] win_errs_reg;
	reg [5:0] zero_run_reg;
	reg [5:0] one_run_reg;
	reg zeros_reg;
	reg ones_reg;
	reg [31:0] bit_cnt_reg;
	reg [23:0] err_cnt_reg;
	reg [3:0] cond_prev_reg;
	reg err_ovf_ev;
	reg bit_ovf_ev;

	wire [2:0] pattern_sel = ctrl1_reg[`PPT_C1_SEL_HI:`PPT_C1_SEL_LO];
	wire rx_invert_en = ctrl1_reg[`PPT_C1_RX_INV];
	wire tx_invert_en = ctrl1_reg[`PPT_C1_TX_INV];
	wire [3:0] repeat_length = ctrl2_reg[`PPT_C2_LEN_HI:`PPT_C2_LEN_LO];
	wire [2:0] error_rate_sel = ctrl2_reg[`PPT_C2_RATE_HI:`PPT_C2_RATE_LO];
	wire [7:0] ctrl1_rise = ctrl1_reg & ~ctrl1_prev_reg;
	wire tx_pattern_load = ctrl1_rise[`PPT_C1_TX_LOAD];
	wire resync_req = ctrl1_rise[`PPT_C1_RESYNC];
	wire clr_counts = ctrl1_rise[`PPT_C1_CLR_COUNTS];
	wire single_error_insert = ctrl2_reg[`PPT_C2_SINGLE_ERR] & ~ctrl2_sbe_prev_reg;
	wire status_rd = bus_rd_i && (bus_addr_i == `PPT_ADDR_STATUS);
	wire is_prbs = (pattern_sel < `PPT_PAT_REPEAT) || (pattern_sel == `PPT_PAT_PRBS9);

	// Two-entry output buffer: head drives the pins, generator stalls when full
	wire fifo_full = fifo_cnt_reg == 2'h2;
	wire gen_push = ~fifo_full;
	wire fifo_pop = tx_ready_i && tx_valid_o;
	wire gen_bit;
	wire rate_hit = (error_rate_sel != 3'h0) && (rate_cnt_reg >= rate_period - 24'h000001);
	wire tx_err = single_err_reg | rate_hit;
	wire tx_data = gen_bit ^ tx_invert_en ^ tx_err;

	wire rx_data = rx_bit_i ^ rx_invert_en;
	wire exp_bit;
	wire rx_match = rx_data == exp_bit;
	wire hunt_adv = rx_valid_i && ~sync_reg;
	wire bit_err = rx_valid_i && sync_reg && ~rx_match;
	wire lose_sync = bit_err && (win_errs_reg + 4'h1 >= `PPT_LOS_ERRS);
	wire gain_sync = hunt_adv && rx_match && (match_cnt_reg == `PPT_SYNC_LAST);
	wire start_hunt = lose_sync || resync_req || tx_pattern_load;
	wire [3:0] cond_now = {ones_reg, zeros_reg, ~sync_reg, sync_reg};

	ppt_pattern_engine #(.STRESS_PAT(STRESS_PAT)) u_gen (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.pattern_sel_i(pattern_sel),
		.repeat_length_i(repeat_length),
		.repeat_pattern_i(repeat_pattern_i),
		.alt_word_count_i(alt_word_count_i),
		.load_i(tx_pattern_load),
		.adv_i(gen_push),
		.seed_i(1'b0),
		.seed_bit_i(1'b0),
		.slip_i(1'b0),
		.bit_o(gen_bit)
	);

	// Hunting: pseudorandom modes self-seed from the line, fixed ones slip a bit
	ppt_pattern_engine #(.STRESS_PAT(STRESS_PAT)) u_chk (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.pattern_sel_i(pattern_sel),
		.repeat_length_i(repeat_length),
		.repeat_pattern_i(repeat_pattern_i),
		.alt_word_count_i(alt_word_count_i),
		.load_i(tx_pattern_load || resync_req),
		.adv_i(rx_valid_i),
		.seed_i(hunt_adv && is_prbs),
		.seed_bit_i(rx_data),
		.slip_i(hunt_adv && ~is_prbs && ~rx_match),
		.bit_o(exp_bit)
	);

	always @*
	begin
		case (error_rate_sel)
			3'h1: rate_period = `PPT_RATE_E1;
			3'h2: rate_period = `PPT_RATE_E2;
			3'h3: rate_period = `PPT_RATE_E3;
			3'h4: rate_period = `PPT_RATE_E4;
			3'h5: rate_period = `PPT_RATE_E5;
			3'h6: rate_period = `PPT_RATE_E6;
			default: rate_period = `PPT_RATE_E7;
		endcase
	end

	// Register port and edge capture
	always @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			ctrl1_reg <= `PPT_RESET_VALUE;
			ctrl2_reg <= `PPT_RESET_VALUE;
			irq_en_reg <= `PPT_RESET_VALUE;
			ctrl1_prev_reg <= `PPT_RESET_VALUE;
			ctrl2_sbe_prev_reg <= 1'b0;
			bus_rdata_o <= 8'h00;
		end
		else
		begin
			ctrl1_prev_reg <= ctrl1_reg;
			ctrl2_sbe_prev_reg <= ctrl2_reg[`PPT_C2_SINGLE_ERR];
			if (bus_wr_i && bus_addr_i == `PPT_ADDR_CTRL1)
				ctrl1_reg <= bus_wdata_i;
			if (bus_wr_i && bus_addr_i == `PPT_ADDR_CTRL2)
				ctrl2_reg <= bus_wdata_i;
			if (bus_wr_i && bus_addr_i == `PPT_ADDR_IRQ_EN)
				irq_en_reg <= {1'b0, bus_wdata_i[6:0]};
			if (bus_rd_i)
			begin
				case (bus_addr_i)
					`PPT_ADDR_STATUS: bus_rdata_o <= {1'b0, status_reg};
					`PPT_ADDR_IRQ_EN: bus_rdata_o <= irq_en_reg;
					`PPT_ADDR_CTRL1: bus_rdata_o <= ctrl1_reg;
					`PPT_ADDR_CTRL2: bus_rdata_o <= ctrl2_reg;
					default: bus_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// Transmit side: error insertion and output buffer
	always @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			single_err_reg <= 1'b0;
			rate_cnt_reg <= 24'h000000;
			tx_bit_o <= 1'b0;
			fifo_b_reg <= 1'b0;
			fifo_cnt_reg <= 2'h0;
			tx_valid_o <= 1'b0;
		end
		else
		begin
			if (single_error_insert)
				single_err_reg <= 1'b1;
			else if (gen_push)
				single_err_reg <= 1'b0;
			if (error_rate_sel == 3'h0)
				rate_cnt_reg <= 24'h000000;
			else if (gen_push)
				rate_cnt_reg <= rate_hit ? 24'h000000 : rate_cnt_reg + 24'h000001;
			case ({gen_push, fifo_pop})
				2'b10:
				begin
					if (fifo_cnt_reg == 2'h0)
						tx_bit_o <= tx_data;
					else
						fifo_b_reg <= tx_data;
					fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
					tx_valid_o <= 1'b1;
				end
				2'b01:
				begin
					tx_bit_o <= fifo_b_reg;
					fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
					tx_valid_o <= fifo_cnt_reg == 2'h2;
				end
				2'b11:
				begin
					tx_bit_o <= (fifo_cnt_reg == 2'h1) ? tx_data : fifo_b_reg;
					fifo_b_reg <= tx_data;
				end
				default:
					tx_valid_o <= fifo_cnt_reg != 2'h0;
			endcase
		end
	end

	// Receive checker: synchronizer, run detectors, counters
	always @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			sync_reg <= 1'b0;
			in_sync_o <= 1'b0;
			match_cnt_reg <= 6'h00;
			win_cnt_reg <= 6'h00;
			win_errs_reg <= 4'h0;
			zero_run_reg <= 6'h00;
			one_run_reg <= 6'h00;
			zeros_reg <= 1'b0;
			ones_reg <= 1'b0;
			bit_cnt_reg <= 32'h00000000;
			err_cnt_reg <= 24'h000000;
			err_ovf_ev <= 1'b0;
			bit_ovf_ev <= 1'b0;
		end
		else
		begin
			err_ovf_ev <= 1'b0;
			bit_ovf_ev <= 1'b0;
			if (start_hunt)
			begin
				sync_reg <= 1'b0;
				in_sync_o <= 1'b0;
				match_cnt_reg <= 6'h00;
			end
			else if (hunt_adv)
			begin
				match_cnt_reg <= rx_match ? match_cnt_reg + 6'h01 : 6'h00;
				sync_reg <= gain_sync;
				in_sync_o <= gain_sync;
			end
			if (~sync_reg || start_hunt)
			begin
				win_cnt_reg <= 6'h00;
				win_errs_reg <= 4'h0;
			end
			else if (rx_valid_i)
			begin
				win_cnt_reg <= win_cnt_reg + 6'h01;
				if (win_cnt_reg == `PPT_LOS_WIN_LAST)
					win_errs_reg <= 4'h0;
				else if (bit_err)
					win_errs_reg <= win_errs_reg + 4'h1;
			end
			if (rx_valid_i)
			begin
				zero_run_reg <= rx_data ? 6'h00 : ((zero_run_reg == `PPT_RUN_LEN) ? zero_run_reg : zero_run_reg + 6'h01);
				one_run_reg <= ~rx_data ? 6'h00 : ((one_run_reg == `PPT_RUN_LEN) ? one_run_reg : one_run_reg + 6'h01);
				zeros_reg <= ~rx_data && (zero_run_reg >= `PPT_RUN_LEN - 6'h01);
				ones_reg <= rx_data && (one_run_reg >= `PPT_RUN_LEN - 6'h01);
			end
			if (clr_counts)
			begin
				bit_cnt_reg <= 32'h00000000;
				err_cnt_reg <= 24'h000000;
			end
			else
			begin
				// Saturating counters: overflow fires once on reaching full
				if (rx_valid_i && sync_reg && bit_cnt_reg != 32'hFFFFFFFF)
				begin
					bit_cnt_reg <= bit_cnt_reg + 32'h00000001;
					bit_ovf_ev <= bit_cnt_reg == 32'hFFFFFFFE;
				end
				if (bit_err && err_cnt_reg != 24'hFFFFFF)
				begin
					err_cnt_reg <= err_cnt_reg + 24'h000001;
					err_ovf_ev <= err_cnt_reg == 24'hFFFFFE;
				end
			end
		end
	end

	// Latched status and pending interrupts; a set in the read cycle survives
	always @*
	begin
		status_next = status_reg;
		pend_next = pend_reg;
		if (status_rd)
		begin
			status_next[`PPT_ST_SYNC] = sync_reg;
			status_next[`PPT_ST_LOST] = status_reg[`PPT_ST_LOST] & ~sync_reg;
			status_next[`PPT_ST_ZEROS] = zeros_reg;
			status_next[`PPT_ST_ONES] = ones_reg;
			status_next[6:4] = 3'h0;
			pend_next = 7'h00;
		end
		if (sync_reg)
			status_next[`PPT_ST_SYNC] = 1'b1;
		// Any restart of the hunt latches, not only a fall of sync
		if (start_hunt || (~sync_reg && cond_prev_reg[1] == 1'b0))
			status_next[`PPT_ST_LOST] = 1'b1;
		if (zeros_reg)
			status_next[`PPT_ST_ZEROS] = 1'b1;
		if (ones_reg)
			status_next[`PPT_ST_ONES] = 1'b1;
		if (err_ovf_ev)
			status_next[`PPT_ST_ERR_OVF] = 1'b1;
		if (bit_ovf_ev)
			status_next[`PPT_ST_BIT_OVF] = 1'b1;
		if (bit_err)
			status_next[`PPT_ST_BIT_ERR] = 1'b1;
		pend_next[3:0] = pend_next[3:0] | (cond_now ^ cond_prev_reg);
		// Events pend on their own strobe so one inside a read is not lost
		pend_next[6:4] = pend_next[6:4] | {bit_err, bit_ovf_ev, err_ovf_ev};
	end

	always @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			status_reg <= 7'h00;
			pend_reg <= 7'h00;
			cond_prev_reg <= 4'h2;
			irq_o <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			pend_reg <= pend_next;
			cond_prev_reg <= cond_now;
			irq_o <= |(pend_next & irq_en_reg[6:0]);
		end
	end
endmodule // ppt_prbs_pattern_tester

// ===== ppt_props.sv
// Port-level properties of the pattern tester.
// Bound onto ppt_prbs_pattern_tester; sees its ports only.
`timescale 1ns/1ps
module ppt_props (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire [7:0] bus_addr_i,
	input wire bus_wr_i,
	input wire bus_rd_i,
	input wire [7:0] bus_wdata_i,
	input wire [7:0] bus_rdata_o,
	input wire tx_ready_i,
	input wire tx_valid_o,
	input wire tx_bit_o,
	input wire rx_valid_i,
	input wire in_sync_o,
	input wire irq_o
);
	reg [6:0] en_reg = 7'h00;
	reg [7:0] c2_reg = 8'h00;
	reg [7:0] hunt_reg = 8'h00;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	always @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			en_reg <= 7'h00;
			c2_reg <= 8'h00;
		end
		else if (bus_wr_i && bus_addr_i == 8'h27)
			en_reg <= bus_wdata_i[6:0];
		else if (bus_wr_i && bus_addr_i == 8'hE1)
			c2_reg <= bus_wdata_i;
	end
	// Saturates so a long hunt cannot wrap
	always @(posedge ref_clk_i)
	begin
		if (sys_rst_i || in_sync_o)
			hunt_reg <= 8'h00;
		else if (rx_valid_i && hunt_reg != 8'hFF)
			hunt_reg <= hunt_reg + 8'h01;
	end
	AST_EN_READ: assert property (bus_rd_i && bus_addr_i == 8'h27 |=> bus_rdata_o == {1'b0, $past(en_reg)})
		else $error("enable readback wrong");
	AST_C2_READ: assert property (bus_rd_i && bus_addr_i == 8'hE1 |=> bus_rdata_o == $past(c2_reg))
		else $error("control 2 readback wrong");
	AST_IRQ_MASKED: assert property (irq_o |-> en_reg != 7'h00 || $past(en_reg) != 7'h00)
		else $error("interrupt while all masked");
	AST_SYNC_32: assert property ($rose(in_sync_o) |-> hunt_reg >= 8'h20)
		else $error("sync before 32 bits");
	AST_SYNC_STATUS: assert property (bus_rd_i && bus_addr_i == 8'h26 && in_sync_o && $past(in_sync_o)
		|=> bus_rdata_o[0]) else $error("sync status missing");
	AST_SYNC_IRQ: assert property ($changed(in_sync_o) && en_reg[0] |=> irq_o)
		else $error("no interrupt on sync change");
	AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i && !(bus_wr_i && bus_addr_i == 8'hE0)
		|=> tx_valid_o && $stable(tx_bit_o)) else $error("held bit changed");
	AST_TX_FILL: assert property ($fell(sys_rst_i) |-> ##[1:3] tx_valid_o)
		else $error("buffer not filled after reset");
endmodule // ppt_props
bind ppt_prbs_pattern_tester ppt_props u_ppt_props (.ref_clk_i, .sys_rst_i, .bus_addr_i, .bus_wr_i, .bus_rd_i,
	.bus_wdata_i, .bus_rdata_o, .tx_ready_i, .tx_valid_o, .tx_bit_o, .rx_valid_i, .in_sync_o, .irq_o);

// ===== ppt_framer_model.sv
// Framer model: takes generated bits, loops them back or sends fixed levels.
// Assumes the tester's clock; mode 0 loop, 2 zeros, 3 ones.
`timescale 1ns/1ps
module ppt_framer_model (
	input wire ref_clk_i,
	input wire slow_i,
	input wire [1:0] mode_i,
	input wire flip_i,
	input wire tx_valid_i,
	input wire tx_bit_i,
	output reg tx_ready_o = 1'b0,
	output reg rx_valid_o = 1'b0,
	output reg rx_bit_o = 1'b0,
	output reg took_o = 1'b0,
	output reg took_bit_o = 1'b0
);
	reg flip_reg = 1'b0;
	wire pop = tx_valid_i && tx_ready_o;
	always @(posedge ref_clk_i)
	begin
		tx_ready_o <= !slow_i || ($urandom % 4 != 0);
		took_o <= pop;
		took_bit_o <= tx_bit_i;
		flip_reg <= flip_i || (flip_reg && !pop);
		rx_valid_o <= mode_i == 2'b00 ? pop : mode_i[1];
		if (mode_i[1])
			rx_bit_o <= mode_i[0];
		else if (pop)
			rx_bit_o <= tx_bit_i ^ flip_reg;
		else
			rx_bit_o <= !rx_bit_o; // Idle line never shows stale data
	end
endmodule // ppt_framer_model

// ===== testbench.sv
// Self-checking bench for the pattern tester with a looping framer model.
// Assumes the tester, its header and the framer model are compiled first.
`timescale 1ns/1ps
module testbench;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [7:0] addr = 8'h00;
	reg [7:0] wdata = 8'h00;
	reg bus_wr = 1'b0;
	reg bus_rd = 1'b0;
	reg [31:0] pat = 32'h00000000;
	reg [7:0] altc = 8'h02;
	reg slow = 1'b0;
	reg [1:0] mode = 2'b00;
	reg flip = 1'b0;
	wire [7:0] rdata;
	wire tx_ready, tx_valid, tx_bit, rx_valid, rx_bit, in_sync, irq, took, took_bit;
	integer err_count = 0;
	integer num_checks = 0;
	integer got, mis, cnt, i, k, run_len, best;
	reg [3:0] len;
	reg rd_seen = 1'b0;
	reg [15:0] ent;
	reg [15:0] expq[$];
	reg bits[0:65599];
	ppt_prbs_pattern_tester #(.STRESS_PAT({8'h01, {54{8'h00}}})) u_ppt_prbs_pattern_tester (.ref_clk_i(clk),
		.sys_rst_i(rst), .bus_addr_i(addr), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_wdata_i(wdata),
		.bus_rdata_o(rdata), .repeat_pattern_i(pat), .alt_word_count_i(altc), .tx_ready_i(tx_ready),
		.tx_valid_o(tx_valid), .tx_bit_o(tx_bit), .rx_valid_i(rx_valid), .rx_bit_i(rx_bit),
		.in_sync_o(in_sync), .irq_o(irq));
	ppt_framer_model u_ppt_framer_model (.ref_clk_i(clk), .slow_i(slow), .mode_i(mode), .flip_i(flip),
		.tx_valid_i(tx_valid), .tx_bit_i(tx_bit), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid),
		.rx_bit_o(rx_bit), .took_o(took), .took_bit_o(took_bit));
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	task report_and_stop;
	begin
		if (err_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			err_count = err_count + 1;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	end
	endtask
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(negedge clk);
		addr = a;
		wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	end
	endtask
	task rd(input [7:0] a, input [7:0] e, input [7:0] m);
	begin
		@(negedge clk);
		addr = a;
		bus_rd = 1'b1;
		expq.push_back({m, e & m});
		@(negedge clk);
		bus_rd = 1'b0;
	end
	endtask
	// Read data lands one cycle after the strobe
	always @(posedge clk)
	begin
		if (rd_seen)
		begin
			ent = expq.pop_front();
			chk("bus_rdata_o", rdata & ent[15:8], ent[7:0]);
		end
		rd_seen = bus_rd;
	end
	task wait_sync(input v);
		integer j;
	begin
		for (j = 0; j < 3000 && in_sync !== v; j = j + 1)
			@(negedge clk);
		chk("in_sync_o", in_sync, v);
		if (in_sync !== v)
			report_and_stop;
	end
	endtask
	task grab(input integer n);
		integer j;
	begin
		got = 0;
		for (j = 0; j < 8 * n + 50 && got < n; j = j + 1)
		begin
			@(posedge clk);
			if (took)
			begin
				bits[got] = took_bit;
				got = got + 1;
			end
		end
		if (got < n)
		begin
			err_count = err_count + 1;
			report_and_stop;
		end
	end
	endtask
	// Old bits still queued in the buffer are skipped
	task measure(input [2:0] code, input inv, input integer p);
	begin
		wr(8'hE0, {1'b0, inv, 1'b0, code, 2'b00});
		wr(8'hE0, {1'b1, inv, 1'b0, code, 2'b00});
		grab(8);
		grab(2 * p);
		mis = 0;
		cnt = 0;
		for (i = 0; i < p; i = i + 1)
		begin
			mis = mis + (bits[i] ^ bits[i + p]);
			cnt = cnt + bits[i];
		end
	end
	endtask
	task run(input [2:0] code, input inv, input integer p, input integer ones);
	begin
		measure(code, inv, p);
		chk("period mismatches", mis, 0);
		chk("ones per period", cnt, ones);
	end
	endtask
	initial
	begin
		void'($urandom(32'hDC1E));
		pat = $urandom;
		len = $urandom;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		rd(8'h26, 8'h00, 8'hFF);
		rd(8'h27, 8'h00, 8'hFF);
		rd(8'hE0, 8'h00, 8'hFF);
		rd(8'hE1, 8'h00, 8'hFF);
		rd(8'h55, 8'h00, 8'hFF);
		wr(8'h27, 8'hFF);
		rd(8'h27, 8'h7F, 8'hFF);
		wr(8'hE1, {4'h0, len});
		rd(8'hE1, {4'h0, len}, 8'hFF);
		slow = 1'b1;
		run(3'h0, 1'b0, 127, 64);
		run(3'h0, 1'b1, 127, 63);
		run(3'h7, 1'b0, 511, 256);
		run(3'h1, 1'b0, 2047, 1024);
		k = 0;
		for (i = 0; i < 17 + len; i = i + 1)
			k = k + pat[i];
		run(3'h4, 1'b0, 17 + len, k);
		run(3'h5, 1'b0, 64, 2 * $countones(pat));
		run(3'h6, 1'b0, 440, 1);
		wr(8'hE1, 8'h07);
		pat = {pat[1:0], {5{pat[5:0]}}};
		run(3'h4, 1'b0, 6, $countones(pat[5:0]));
		measure(3'h3, 1'b0, 1500);
		run_len = 0;
		best = 0;
		for (i = 0; i < 3000; i = i + 1)
		begin
			run_len = bits[i] ? 0 : run_len + 1;
			best = run_len > best ? run_len : best;
		end
		chk("longest zero run", best <= 14, 1);
		for (k = 1; k <= 7; k = k + 1)
		begin
			wr(8'hE1, {k[2:0], 1'b0, len});
			rd(8'hE1, {k[2:0], 1'b0, len}, 8'hFF);
			if (k < 3)
				measure(3'h0, 1'b0, 127);
			if (k < 3)
				chk("inserted errors", mis >= (k == 1 ? 25 : 2) && mis <= (k == 1 ? 26 : 3), 1);
		end
		wr(8'hE1, {4'h0, len});
		slow = 1'b0;
		run(3'h2, 1'b0, 32767, 16384);
		wr(8'h27, 8'h41);
		wr(8'hE0, 8'h00);
		wr(8'hE0, 8'h80);
		wait_sync(1'b0);
		wait_sync(1'b1);
		repeat (3) @(negedge clk);
		chk("irq_o", irq, 1);
		rd(8'h26, 8'h01, 8'h01);
		rd(8'h26, 8'h01, 8'h43);
		flip = 1'b1;
		@(negedge clk);
		flip = 1'b0;
		repeat (10) @(negedge clk);
		chk("irq_o", irq, 1);
		rd(8'h26, 8'h41, 8'h41);
		wr(8'hE1, 8'h10);
		repeat (20) @(negedge clk);
		rd(8'h26, 8'h41, 8'h41);
		repeat (20) @(negedge clk);
		rd(8'h26, 8'h01, 8'h41);
		wr(8'h27, 8'h01);
		chk("irq_o", irq, 0);
		wr(8'hE0, 8'hA0);
		wait_sync(1'b0);
		repeat (3) @(negedge clk);
		chk("irq_o", irq, 1);
		rd(8'h26, 8'h02, 8'h02);
		wr(8'hE0, 8'hE0);
		wait_sync(1'b1);
		wr(8'hE0, 8'h80);
		mode = 2'b10;
		repeat (40) @(negedge clk);
		rd(8'h26, 8'h04, 8'h04);
		mode = 2'b11;
		repeat (40) @(negedge clk);
		rd(8'h26, 8'h0C, 8'h0C);
		rd(8'h26, 8'h08, 8'h0C);
		mode = 2'b00;
		wait_sync(1'b1);
		rd(8'h26, 8'h01, 8'h01);
		wr(8'hE0, 8'h81);
		wait_sync(1'b0);
		wait_sync(1'b1);
		rd(8'h26, 8'h03, 8'h03);
		repeat (3) @(negedge clk);
		report_and_stop;
	end
endmodule // testbench
